// *** nscfg_pkg.sv ***
package nscfg_pkg;
  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_SWCFG   = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFS_EVENT   = 8'h18;

  // ---------------------------------------------------------------
  // values after reset and limits
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_DEFAULT = 6'h3f;
  localparam logic [6:0] ADDR_SW_MIN  = 7'h40;
  localparam logic [6:0] SWITCH_MAX   = 7'h63;
  localparam logic [1:0] BAUD_DEFAULT = 2'h0;
  // cycles the switch synchronisers need before the power-on sample
  localparam logic [1:0] PU_WAIT      = 2'h2;

  // ctrl bits
  localparam int CTRL_CFG_RESET = 0;
  localparam int CTRL_RESET_CMD = 1;
  localparam int CTRL_STANDALONE = 2;
  localparam int CTRL_HOLD      = 3;
  // event register bits (write one pulses)
  localparam int EV_RUN_IDLE  = 0;
  localparam int EV_CFG_MODE  = 1;
  localparam int EV_COMM_ERR  = 2;
  localparam int EV_CRIT_ERR  = 3;
  localparam int EV_DUP_ADDR  = 4;
  localparam int EV_BAUD_DET  = 5;
  // interrupt status bits
  localparam int IRQ_ABORT    = 0;
  localparam int IRQ_DUP      = 1;
  localparam int IRQ_CLEAR    = 2;
  localparam int IRQ_W        = 3;

  typedef enum logic [1:0] {
    NSCFG_BAUD_125 = 2'h0,
    NSCFG_BAUD_250 = 2'h1,
    NSCFG_BAUD_500 = 2'h2
  } nscfg_baud_t;

  typedef enum logic [1:0] {
    NSCFG_SRC_FIXED,
    NSCFG_SRC_SOFT,
    NSCFG_SRC_AUTO
  } nscfg_bsrc_t;

  typedef enum {
    NSCFG_ST_POWERUP,
    NSCFG_ST_RUN,
    NSCFG_ST_ABORT
  } nscfg_state_t;

  typedef struct packed {
    logic [6:0] addr_sw;
    logic [3:0] baud_sw;
  } nscfg_sw_t;

  typedef struct packed {
    logic       haddr_ok;
    logic [7:0] addr;
    logic       write;
  } nscfg_aph_t;

  // decode two bcd digits to binary 0..99
  function automatic logic [6:0] bcd2bin(input logic [7:0] bcd);
    logic [6:0] tens;
    tens = {3'h0, bcd[7:4]};
    bcd2bin = 7'((tens << 3) + (tens << 1) + {3'h0, bcd[3:0]});
  endfunction
endpackage

// *** nscfg_top.sv ***
// Function
// R1: switch value 0..63 sets node address
// R2: switch 64..99 uses stored software address
// R3: default node address is 63
// R4: address switch change while powered aborts
// R5: duplicate address flags error, blocks comms
// R6: decode baud dip switch pins
// R7: default baud rate is 125 kbit/s
// R8: software baud takes effect after reset
// R9: auto baud adopts master rate until power-on
// R10: some master must have fixed baud
// R11: baud switch change while powered aborts
// R12: all nodes share one baud rate
// R13: config reset returns settings to defaults
// R14: standalone disables network after reset
// R15: safety area cleared on idle, config, power-on
// R16: comm error clears failed connection only
// R17: standard area honours hold on idle, error
// R18: hold keeps data except critical, abort, power; the code also clears it on config
// R19: sample switches at power-on, then compare
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
module nscfg_top #(
  parameter int NCONN = 4
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [7:0]        node_sw,
  input  wire logic [3:0]        baud_sw,
  output logic      [5:0]        node_addr,
  output logic      [1:0]        baud_rate,
  output logic                   net_enable,
  output logic                   standalone_disp,
  output logic                   abort_state,
  output logic                   dup_addr_err,
  output logic      [NCONN-1:0]  safe_clear,
  output logic      [NCONN-1:0]  std_clear,
  output logic                   irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           nsw_s1;
    logic [7:0]           nsw_s2;
    logic [3:0]           bsw_s1;
    logic [3:0]           bsw_s2;
    nscfg_pkg::nscfg_state_t st;
    logic [1:0]           pu_cnt;
    logic                 nen;
    nscfg_pkg::nscfg_sw_t snap;
    nscfg_pkg::nscfg_bsrc_t bsrc;
    logic                 addr_soft;
    logic [5:0]           sw_addr;
    logic [1:0]           sw_baud;
    logic [1:0]           stored_baud;
    logic                 stored_alone;
    logic                 pend_alone;
    logic                 hold;
    logic                 baud_locked;
    logic [5:0]           addr;
    logic [1:0]           baud;
    logic                 alone;
    logic                 abort;
    logic                 dup;
    logic [NCONN-1:0]     sclr;
    logic [NCONN-1:0]     tclr;
    logic [NCONN-1:0]     conn_sel;
    logic [2:0]           irq_st;
    logic [2:0]           irq_en;
    logic                 irq;
    nscfg_pkg::nscfg_aph_t aph;
    logic [31:0]          rdata;
  } nscfg_reg_t;

  nscfg_reg_t r;
  nscfg_reg_t nx;

  function automatic logic [1:0] baud_decode(input logic [3:0] sw);
    baud_decode = sw[1] ? 2'(nscfg_pkg::NSCFG_BAUD_500) :
                  sw[0] ? 2'(nscfg_pkg::NSCFG_BAUD_250) : 2'(nscfg_pkg::NSCFG_BAUD_125);
  endfunction

  function automatic nscfg_pkg::nscfg_bsrc_t baud_source(input logic [3:0] sw);
    if (sw[3]) begin
      baud_source = nscfg_pkg::NSCFG_SRC_AUTO;
    end else if (sw[2] || (sw[1] && sw[0])) begin
      baud_source = nscfg_pkg::NSCFG_SRC_SOFT;
    end else begin
      baud_source = nscfg_pkg::NSCFG_SRC_FIXED;
    end
  endfunction

  logic [6:0] live_addr;
  logic       wr_go;
  logic       ap_go;
  logic [31:0] wd;
  logic       do_reset;
  logic [NCONN-1:0] all_ones;

  assign live_addr = nscfg_pkg::bcd2bin(r.nsw_s2);
  assign ap_go     = hsel && hready && htrans[1];
  assign wr_go     = r.aph.haddr_ok && r.aph.write;
  assign wd        = hwdata;
  assign all_ones  = {NCONN{1'b1}};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nx = r;
    do_reset = 1'b0;
    nx.nsw_s1 = node_sw;
    nx.nsw_s2 = r.nsw_s1;
    nx.bsw_s1 = baud_sw;
    nx.bsw_s2 = r.bsw_s1;
    nx.sclr = '0;
    nx.tclr = '0;
    nx.aph.haddr_ok = ap_go;
    nx.aph.addr = haddr[7:0];
    nx.aph.write = hwrite;

    // bus writes
    if (wr_go) begin
      if (r.aph.addr == nscfg_pkg::OFS_CTRL) begin
        nx.pend_alone = wd[nscfg_pkg::CTRL_STANDALONE];
        nx.hold = wd[nscfg_pkg::CTRL_HOLD];
        if (wd[nscfg_pkg::CTRL_CFG_RESET]) begin
          nx.sw_addr = nscfg_pkg::ADDR_DEFAULT; // R13
          nx.sw_baud = nscfg_pkg::BAUD_DEFAULT; // R13
          nx.pend_alone = 1'b0; // R13
          nx.hold = 1'b0; // R13
        end
        do_reset = wd[nscfg_pkg::CTRL_RESET_CMD];
      end else if (r.aph.addr == nscfg_pkg::OFS_SWCFG) begin
        nx.sw_addr = wd[5:0];
        nx.sw_baud = (wd[9:8] > 2'h2) ? nscfg_pkg::BAUD_DEFAULT : wd[9:8];
      end else if (r.aph.addr == nscfg_pkg::OFS_IRQ_EN) begin
        nx.irq_en = wd[2:0];
      end else if (r.aph.addr == nscfg_pkg::OFS_IRQ_CLR) begin
        nx.irq_st = r.irq_st & ~wd[2:0];
      end else if (r.aph.addr == nscfg_pkg::OFS_EVENT) begin
        nx.conn_sel = wd[8 +: NCONN];
        if (wd[nscfg_pkg::EV_RUN_IDLE]) begin
          nx.sclr = all_ones; // R15
          nx.tclr = r.hold ? '0 : all_ones; // R17
        end
        if (wd[nscfg_pkg::EV_CFG_MODE]) begin
          nx.sclr = all_ones; // R15
          nx.tclr = all_ones; // R17
        end
        if (wd[nscfg_pkg::EV_COMM_ERR]) begin
          nx.sclr = nx.sclr | wd[8 +: NCONN]; // R16
          nx.tclr = nx.tclr | (r.hold ? '0 : wd[8 +: NCONN]); // R16 R17
        end
        if (wd[nscfg_pkg::EV_CRIT_ERR]) begin
          nx.tclr = all_ones; // R18
        end
        if (wd[nscfg_pkg::EV_DUP_ADDR] && !r.alone) begin
          nx.dup = 1'b1; // R5
        end
        if (wd[nscfg_pkg::EV_BAUD_DET] && r.bsrc == nscfg_pkg::NSCFG_SRC_AUTO && !r.baud_locked) begin
          nx.baud = (wd[17:16] > 2'h2) ? nscfg_pkg::BAUD_DEFAULT : wd[17:16]; // R9
          nx.baud_locked = 1'b1; // R9
        end
      end
    end

    case (r.st)
      nscfg_pkg::NSCFG_ST_POWERUP: begin
        // the synchronisers restart from zero, so wait until they carry the switches
        if (r.pu_cnt != nscfg_pkg::PU_WAIT) begin
          nx.pu_cnt = r.pu_cnt + 2'h1;
        end else begin
        nx.pu_cnt = 2'h0;
        nx.snap.addr_sw = live_addr; // R19
        nx.snap.baud_sw = r.bsw_s2; // R19
        nx.bsrc = baud_source(r.bsw_s2); // R6
        nx.addr_soft = live_addr >= nscfg_pkg::ADDR_SW_MIN; // R2
        nx.addr = (live_addr >= nscfg_pkg::ADDR_SW_MIN) ? r.sw_addr : live_addr[5:0]; // R1 R2
        if (baud_source(r.bsw_s2) == nscfg_pkg::NSCFG_SRC_FIXED) begin
          nx.baud = baud_decode(r.bsw_s2); // R6
        end else begin
          nx.baud = r.stored_baud; // R8 R9
        end
        nx.baud_locked = 1'b0;
        nx.alone = r.stored_alone; // R14
        nx.dup = 1'b0;
        nx.sclr = all_ones; // R15
        nx.tclr = all_ones; // R17
        nx.st = nscfg_pkg::NSCFG_ST_RUN;
        end
      end
      nscfg_pkg::NSCFG_ST_RUN: begin
        if (live_addr != r.snap.addr_sw || r.bsw_s2 != r.snap.baud_sw) begin
          nx.abort = 1'b1; // R4 R11
          nx.tclr = all_ones; // R18
          nx.sclr = all_ones;
          nx.st = nscfg_pkg::NSCFG_ST_ABORT;
        end
      end
      nscfg_pkg::NSCFG_ST_ABORT: begin
        nx.abort = 1'b1;
      end
      default: nx.st = nscfg_pkg::NSCFG_ST_POWERUP;
    endcase

    if (do_reset) begin
      nx.stored_baud = r.sw_baud; // R8
      nx.stored_alone = r.pend_alone; // R14
      nx.abort = 1'b0;
      nx.st = nscfg_pkg::NSCFG_ST_POWERUP;
    end

    nx.nen = !nx.alone && !nx.dup && !nx.abort && nx.st == nscfg_pkg::NSCFG_ST_RUN; // R5 R14

    // interrupts: set wins over clear
    nx.irq_st = nx.irq_st | {(nx.sclr != '0 || nx.tclr != '0), (nx.dup && !r.dup), (nx.abort && !r.abort)};
    nx.irq = (nx.irq_st & nx.irq_en) != 3'h0;

    // read data
    nx.rdata = 32'h0;
    if (ap_go && !hwrite) begin
      if (haddr[7:0] == nscfg_pkg::OFS_CTRL) begin
        nx.rdata = {28'h0, r.hold, r.pend_alone, 2'h0};
      end else if (haddr[7:0] == nscfg_pkg::OFS_SWCFG) begin
        nx.rdata = {22'h0, r.sw_baud, 2'h0, r.sw_addr};
      end else if (haddr[7:0] == nscfg_pkg::OFS_STATUS) begin
        nx.rdata = {9'h0, 2'(r.bsrc), r.baud, 1'b0, r.snap.addr_sw, r.addr_soft, r.baud_locked,
                    r.alone, r.dup, r.abort, r.addr};
      end else if (haddr[7:0] == nscfg_pkg::OFS_IRQ_ST) begin
        nx.rdata = {29'h0, r.irq_st};
      end else if (haddr[7:0] == nscfg_pkg::OFS_IRQ_EN) begin
        nx.rdata = {29'h0, r.irq_en};
      end else begin
        nx.rdata = 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.st <= nscfg_pkg::NSCFG_ST_POWERUP;
      r.sw_addr <= nscfg_pkg::ADDR_DEFAULT; // R3
      r.sw_baud <= nscfg_pkg::BAUD_DEFAULT; // R7
      r.stored_baud <= nscfg_pkg::BAUD_DEFAULT; // R7
      r.addr <= nscfg_pkg::ADDR_DEFAULT; // R3
    end else begin
      r <= nx;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata          = r.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign node_addr       = r.addr;
  assign baud_rate       = r.baud;
  assign net_enable      = r.nen; // R5 R14
  assign standalone_disp = r.alone; // R14
  assign abort_state     = r.abort;
  assign dup_addr_err    = r.dup;
  assign safe_clear      = r.sclr;
  assign std_clear       = r.tclr;
  assign irq             = r.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  addr_switch_a: assert property (r.st == nscfg_pkg::NSCFG_ST_POWERUP && r.pu_cnt == nscfg_pkg::PU_WAIT
    && live_addr < nscfg_pkg::ADDR_SW_MIN
    |=> node_addr == $past(live_addr[5:0])) else $error("node address not from switch"); // R1
  addr_soft_a: assert property (r.st == nscfg_pkg::NSCFG_ST_POWERUP && r.pu_cnt == nscfg_pkg::PU_WAIT
    && live_addr >= nscfg_pkg::ADDR_SW_MIN
    |=> node_addr == $past(r.sw_addr)) else $error("soft address not used"); // R2
  addr_default_a: assert property ($rose(hresetn) |-> r.sw_addr == nscfg_pkg::ADDR_DEFAULT)
    else $error("default address wrong"); // R3
  sw_abort_a: assert property (r.st == nscfg_pkg::NSCFG_ST_RUN && !do_reset && live_addr != r.snap.addr_sw
    |=> abort_state && std_clear == all_ones) else $error("no abort on switch change"); // R4
  baud_abort_a: assert property (r.st == nscfg_pkg::NSCFG_ST_RUN && !do_reset && r.bsw_s2 != r.snap.baud_sw
    |=> abort_state) else $error("no abort on baud change"); // R11
  dup_block_a: assert property (dup_addr_err |-> !net_enable) else $error("comms with dup"); // R5
  baud_fixed_a: assert property (r.st == nscfg_pkg::NSCFG_ST_POWERUP && r.pu_cnt == nscfg_pkg::PU_WAIT
    && r.bsw_s2 == 4'h1
    |=> baud_rate == 2'(nscfg_pkg::NSCFG_BAUD_250)) else $error("baud decode wrong"); // R6
  powerup_clr_a: assert property (r.st == nscfg_pkg::NSCFG_ST_POWERUP && r.pu_cnt == nscfg_pkg::PU_WAIT
    |=> safe_clear == all_ones && std_clear == all_ones) else $error("power-on clear missing"); // R15
  alone_a: assert property (standalone_disp |-> !net_enable) else $error("standalone yet enabled"); // R14
  hold_a: assert property (wr_go && r.aph.addr == nscfg_pkg::OFS_EVENT && r.hold && wd[7:0] == 8'h01
    && r.st == nscfg_pkg::NSCFG_ST_RUN && live_addr == r.snap.addr_sw && r.bsw_s2 == r.snap.baud_sw
    |=> std_clear == '0 && safe_clear == all_ones) else $error("hold not honoured"); // R17 R18

  idle_cov: cover property (wr_go && r.aph.addr == nscfg_pkg::OFS_EVENT && wd[nscfg_pkg::EV_RUN_IDLE]);
  abort_cov: cover property (r.st == nscfg_pkg::NSCFG_ST_RUN ##1 abort_state);
  auto_cov: cover property (!r.baud_locked ##1 r.baud_locked);
endmodule

// *** nscfg_panel.sv ***
// ---------------------------------------------------------------
// switch panel and a fixed-rate network master
// ---------------------------------------------------------------
module nscfg_panel #(
  parameter logic [1:0] MASTER_RATE = 2'h2
) (
  input  wire logic       hclk,
  output logic      [7:0] node_sw,
  output logic      [3:0] baud_sw,
  output logic      [1:0] master_rate
);
  timeunit 1ns;
  timeprecision 1ps;
  // the master that sets the rate keeps it fixed, every node follows it
  assign master_rate = MASTER_RATE;
  initial begin
    node_sw = 8'h07;
    baud_sw = 4'h0;
  end
  task automatic set(input logic [7:0] n, input logic [3:0] b);
    @(posedge hclk);
    node_sw <= n;
    baud_sw <= b;
  endtask
endmodule

// *** nscfg_top_tb.sv ***
module nscfg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, acc_clr = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]  htrans = 2'h0, baud_rate, master_rate;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  node_sw;
  logic [3:0]  baud_sw, safe_clear, std_clear, sc_acc = 4'h0, st_acc = 4'h0;
  logic [5:0]  node_addr;
  logic        hreadyout, hresp, net_enable, standalone_disp, abort_state, dup_addr_err, irq;
  int          n_mismatch = 0;
  int          tests_run  = 0;

  initial forever #5 hclk = ~hclk;

  nscfg_panel nscfg_panel_inst (.hclk(hclk), .node_sw(node_sw), .baud_sw(baud_sw), .master_rate(master_rate));

  nscfg_top nscfg_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .node_sw(node_sw), .baud_sw(baud_sw), .node_addr(node_addr), .baud_rate(baud_rate),
    .net_enable(net_enable), .standalone_disp(standalone_disp), .abort_state(abort_state),
    .dup_addr_err(dup_addr_err), .safe_clear(safe_clear), .std_clear(std_clear), .irq(irq));

  // collects the one-cycle clear pulses between two checks
  always @(posedge hclk) begin
    sc_acc <= acc_clr ? 4'h0 : (sc_acc | safe_clear);
    st_acc <= acc_clr ? 4'h0 : (st_acc | std_clear);
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      summarize();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic settle;
    repeat (8) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic ev(input logic [31:0] d);
    acc_clr <= 1'b1;
    @(posedge hclk);
    acc_clr <= 1'b0;
    wr(nscfg_pkg::OFS_EVENT, d);
    settle();
  endtask

  task automatic rst(input logic [7:0] n, input logic [3:0] b);
    @(posedge hclk);
    hresetn <= 1'b0;
    acc_clr <= 1'b1;
    nscfg_panel_inst.set(n, b);
    repeat (15) @(posedge hclk);
    hresetn <= 1'b1;
    acc_clr <= 1'b0;
    settle();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_switch;
    logic [7:0] nv [4] = '{8'h00, 8'h12, 8'h63, 8'h99};
    logic [5:0] ea [4] = '{6'd0, 6'd12, 6'd63, 6'd63};
    logic [3:0] bv [4] = '{4'h0, 4'h1, 4'h2, 4'h0};
    logic [1:0] eb [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    for (int i = 0; i < 4; i++) begin
      rst(nv[i], bv[i]);
      chk(node_addr, ea[i], "node address");
      chk(baud_rate, eb[i], "baud rate");
      chk(sc_acc, 4'hf, "safety clear at power-on");
      chk(st_acc, 4'hf, "standard clear at power-on");
      bus(1'b0, nscfg_pkg::OFS_STATUS, 32'h0, q);
      chk(q[5:0], ea[i], "status address");
      chk(hresp, 1'b0, "bus response okay");
      chk(hreadyout, 1'b1, "bus ready");
    end
    $display("test switches done");
  endtask

  task automatic t_abort;
    rst(8'h07, 4'h0);
    wr(nscfg_pkg::OFS_IRQ_EN, 32'h1);
    chk(irq, 1'b0, "irq idle");
    acc_clr <= 1'b1;
    nscfg_panel_inst.set(8'h08, 4'h0);
    acc_clr <= 1'b0;
    settle();
    chk(abort_state, 1'b1, "abort on address change");
    chk(net_enable, 1'b0, "network off in abort");
    chk(st_acc, 4'hf, "standard clear on abort");
    chk(irq, 1'b1, "irq on abort");
    bus(1'b0, nscfg_pkg::OFS_IRQ_ST, 32'h0, q);
    chk(q[0], 1'b1, "abort status bit");
    wr(nscfg_pkg::OFS_IRQ_EN, 32'h0);
    settle();
    chk(irq, 1'b0, "irq masked");
    wr(nscfg_pkg::OFS_IRQ_CLR, 32'h1);
    bus(1'b0, nscfg_pkg::OFS_IRQ_ST, 32'h0, q);
    chk(q[0], 1'b0, "abort status cleared");
    bus(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    rst(8'h07, 4'h0);
    nscfg_panel_inst.set(8'h07, 4'h2);
    settle();
    chk(abort_state, 1'b1, "abort on baud change");
    $display("test abort done");
  endtask

  task automatic t_soft;
    rst(8'h70, 4'h3);
    chk(node_addr, 6'd63, "stored address default");
    chk(baud_rate, 2'h0, "stored baud default");
    wr(nscfg_pkg::OFS_CTRL, 32'h1);
    wr(nscfg_pkg::OFS_SWCFG, 32'h205);
    wr(nscfg_pkg::OFS_CTRL, 32'h4);
    settle();
    chk(baud_rate, 2'h0, "soft baud pending");
    chk(net_enable, 1'b1, "standalone pending");
    wr(nscfg_pkg::OFS_CTRL, 32'h6);
    settle();
    chk(node_addr, 6'd5, "soft address");
    chk(baud_rate, 2'h2, "soft baud after reset command");
    chk(standalone_disp, 1'b1, "standalone shown");
    chk(net_enable, 1'b0, "standalone network off");
    wr(nscfg_pkg::OFS_CTRL, 32'h1);
    wr(nscfg_pkg::OFS_CTRL, 32'h2);
    settle();
    chk(node_addr, 6'd63, "config reset address");
    chk(baud_rate, 2'h0, "config reset baud");
    chk(net_enable, 1'b1, "config reset network");
    $display("test soft done");
  endtask

  task automatic t_net;
    rst(8'h07, 4'h8);
    ev({14'h0, master_rate, 16'h20});
    chk(baud_rate, master_rate, "auto baud adopted");
    ev({14'h0, 2'h1, 16'h20});
    chk(baud_rate, master_rate, "auto baud kept");
    rst(8'h07, 4'h0);
    ev(32'h404);
    chk(sc_acc, 4'h4, "safety clear one connection");
    chk(st_acc, 4'h4, "standard clear one connection");
    wr(nscfg_pkg::OFS_CTRL, 32'h8);
    ev(32'h404);
    chk(st_acc, 4'h0, "hold on comm error");
    ev(32'h1);
    chk(sc_acc, 4'hf, "safety clear on idle");
    chk(st_acc, 4'h0, "hold on idle");
    ev(32'h8);
    chk(st_acc, 4'hf, "clear on critical error");
    ev(32'h2);
    chk(sc_acc, 4'hf, "safety clear on config");
    chk(st_acc, 4'hf, "standard clear on config");
    ev(32'h10);
    chk(dup_addr_err, 1'b1, "duplicate flagged");
    chk(net_enable, 1'b0, "duplicate blocks network");
    $display("test network done");
  endtask

  initial begin
    t_switch();
    t_abort();
    t_soft();
    t_net();
    summarize();
  end
endmodule
